// file: dmpd_regs.vh
// Constants for the dual-modulus PLL divider core
`ifndef DMPD_REGS_VH
`define DMPD_REGS_VH
`define DMPD_N_WIDTH 10
`define DMPD_A_WIDTH 6
`define DMPD_SEL_WIDTH 3
`define DMPD_REF_WIDTH 11
`define DMPD_N_MIN 10'h003
`define DMPD_REF_DIV0 12'h008
`define DMPD_REF_DIV1 12'h040
`define DMPD_REF_DIV2 12'h080
`define DMPD_REF_DIV3 12'h100
`define DMPD_REF_DIV4 12'h200
`define DMPD_REF_DIV5 12'h400
`define DMPD_REF_DIV6 12'h488
`define DMPD_REF_DIV7 12'h800
`define DMPD_PD_PULSE 4'h2
`define DMPD_LOCK_HOLD 4'h4
`endif

// file: dmpd_sync.v
// Two-flop synchroniser for a pin level
`timescale 1ns/100ps
module dmpd_sync #(
   parameter WIDTH = 1
) (
   input wire SYS_CLK,
   input wire RESETN,
   input wire [WIDTH-1:0] D_IN,
   output wire [WIDTH-1:0] D_OUT
);
   reg [WIDTH-1:0] meta_r; // First stage, read only by second
   reg [WIDTH-1:0] sync_r; // Second stage
   // Both stages reset to constants
   always @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         meta_r <= {WIDTH{1'b0}};
         sync_r <= {WIDTH{1'b0}};
      end else begin
         meta_r <= D_IN;
         sync_r <= meta_r;
      end
   end
   assign D_OUT = sync_r;
endmodule

// file: dmpd_core.v
// Dual-modulus PLL divider: reference divider, N/A counters, phase detector
//
// How it works
// - select picks reference ratio 8 to 2048
// - sixteen static preset lines plus three select
// - N counter is 10-bit, range 3-1023
// - A counter is 6-bit, range 0-63
// - N reloads from preset on the edge after it reaches one
// - counters advance on divider input rising edges
// - modulus control low until A done
// - modulus control high for remaining N-A counts
// - at N done, reload, go low unless A preset is zero, repeat
// - open configuration lines read as one
// - VCO fast or leading pulses VCO output low
// - VCO slow or lagging pulses reference output low
// - locked: both pulse low briefly together
// - lock indicator high locked, pulses low otherwise
// - crystal or external reference, same logic
`timescale 1ns/100ps
`include "dmpd_regs.vh"
module dmpd_core #(
   parameter PD_PULSE = `DMPD_PD_PULSE,
   parameter LOCK_HOLD = `DMPD_LOCK_HOLD
) (
   input wire SYS_CLK,
   input wire RESETN,
   input wire REF_OSC_INPUT,
   input wire DIVIDER_INPUT,
   input wire [2:0] REF_DIVIDE_SELECT,
   input wire [9:0] N_PRESET_VALUE,
   input wire [5:0] A_PRESET_VALUE,
   output wire REF_OSC_OUTPUT,
   output reg MODULUS_CONTROL,
   output reg PHASE_REF_N,
   output reg PHASE_VCO_N,
   output reg LOCK_INDICATOR,
   output reg DIVIDED_VCO_FREQ,
   output reg DIVIDED_REF_FREQ
);
   // Reference ratio lookup, used only for the reference counter reload value
   function [11:0] ref_ratio;
      input [2:0] sel;
      begin
         case (sel)
            3'h0: ref_ratio = `DMPD_REF_DIV0;
            3'h1: ref_ratio = `DMPD_REF_DIV1;
            3'h2: ref_ratio = `DMPD_REF_DIV2;
            3'h3: ref_ratio = `DMPD_REF_DIV3;
            3'h4: ref_ratio = `DMPD_REF_DIV4;
            3'h5: ref_ratio = `DMPD_REF_DIV5;
            3'h6: ref_ratio = `DMPD_REF_DIV6;
            default: ref_ratio = `DMPD_REF_DIV7;
         endcase
      end
   endfunction

   // All pins synchronised; config lines too since they are static switches
   wire [20:0] pin_sync;
   dmpd_sync #(
      .WIDTH(21)
   ) u_sync (
      .SYS_CLK(SYS_CLK),
      .RESETN(RESETN),
      .D_IN({REF_OSC_INPUT, DIVIDER_INPUT, REF_DIVIDE_SELECT, N_PRESET_VALUE,
         A_PRESET_VALUE}),
      .D_OUT(pin_sync)
   );
   wire osc_s = pin_sync[20]; // Reference clock level
   wire fin_s = pin_sync[19]; // Divider input level
   wire [2:0] sel_s = pin_sync[18:16];
   wire [9:0] n_s = pin_sync[15:6];
   wire [5:0] a_s = pin_sync[5:0];

   // Unconnected lines are pulled up outside; logic needs no special case
   // (pads supply the pull-ups)

   // Oscillator output is the inverted input; in external mode left open
   assign REF_OSC_OUTPUT = ~REF_OSC_INPUT;

   reg osc_d_r; // Previous reference level for edge detect
   reg fin_d_r; // Previous divider-input level
   reg [2:0] warm_r; // Fills with ones after reset
   // Edges stay masked until the history flops hold real pin levels, so a pin
   // sitting high at reset release gives no false edge; a true edge in the
   // first cycle after reset release is lost, which is the price of that
   wire armed = warm_r[2];
   wire osc_rise = armed & osc_s & ~osc_d_r;
   wire fin_rise = armed & fin_s & ~fin_d_r;

   // Edge detector history and startup mask
   always @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         osc_d_r <= 1'b0;
         fin_d_r <= 1'b0;
         warm_r <= 3'h0;
      end else begin
         osc_d_r <= osc_s;
         fin_d_r <= fin_s;
         warm_r <= {warm_r[1:0], 1'b1};
      end
   end

   // Reference divider: counts ratio-1 down to zero
   reg [10:0] ref_cnt_r;
   reg ref_evt_r; // One-cycle divided reference event
   // Reload is ratio minus one; 2048 only fits the 11-bit counter that way
   wire [11:0] ref_reload = ref_ratio(sel_s) - 12'h001;
   always @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         ref_cnt_r <= 11'h000;
         ref_evt_r <= 1'b0;
      end else begin
         ref_evt_r <= 1'b0;
         if (osc_rise) begin
            if (ref_cnt_r == 11'h000) begin
               ref_cnt_r <= ref_reload[10:0];
               ref_evt_r <= 1'b1;
            end else begin
               ref_cnt_r <= ref_cnt_r - 11'h001;
            end
         end
      end
   end

   // N and A down-counters with modulus control
   reg [9:0] n_cnt_r;
   reg [5:0] a_cnt_r;
   reg vco_evt_r; // One-cycle divided VCO event
   // A zero preset means the low phase is empty from the start
   always @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         n_cnt_r <= 10'h000;
         a_cnt_r <= 6'h00;
         MODULUS_CONTROL <= 1'b0;
         vco_evt_r <= 1'b0;
      end else begin
         vco_evt_r <= 1'b0;
         if (fin_rise) begin
            if (n_cnt_r <= 10'h001) begin
               // Cycle ends: reload both, back to low unless the A preset is zero
               n_cnt_r <= n_s;
               a_cnt_r <= a_s;
               MODULUS_CONTROL <= (a_s == 6'h00);
               vco_evt_r <= 1'b1;
            end else begin
               n_cnt_r <= n_cnt_r - 10'h001;
               if (a_cnt_r != 6'h00) begin
                  a_cnt_r <= a_cnt_r - 6'h01;
                  // High once A has finished; relies on N >= A
                  MODULUS_CONTROL <= (a_cnt_r == 6'h01);
               end
            end
         end
      end
   end

   // Phase/frequency detector: two flags, reset when both set
   reg up_r; // Reference arrived first
   reg dn_r; // VCO arrived first
   reg [3:0] pr_cnt_r; // Low-pulse stretch for reference side
   reg [3:0] pv_cnt_r; // Low-pulse stretch for VCO side
   localparam [3:0] pulse_len = PD_PULSE[3:0]; // Stretch counters are 4 bits
   wire both = (up_r | ref_evt_r) & (dn_r | vco_evt_r);
   always @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         up_r <= 1'b0;
         dn_r <= 1'b0;
         pr_cnt_r <= 4'h0;
         pv_cnt_r <= 4'h0;
      end else begin
         if (both) begin
            up_r <= 1'b0;
            dn_r <= 1'b0;
            // Minimum-width pulse on both outputs when in phase
            pr_cnt_r <= pulse_len;
            pv_cnt_r <= pulse_len;
         end else begin
            up_r <= up_r | ref_evt_r;
            dn_r <= dn_r | vco_evt_r;
            if (pr_cnt_r != 4'h0)
               pr_cnt_r <= pr_cnt_r - 4'h1;
            if (pv_cnt_r != 4'h0)
               pv_cnt_r <= pv_cnt_r - 4'h1;
         end
      end
   end

   // Registered active-low phase outputs
   always @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         PHASE_REF_N <= 1'b1;
         PHASE_VCO_N <= 1'b1;
      end else begin
         PHASE_REF_N <= ~(up_r | (pr_cnt_r != 4'h0));
         PHASE_VCO_N <= ~(dn_r | (pv_cnt_r != 4'h0));
      end
   end

   // Lock: low once only one side has been pending for LOCK_HOLD cycles
   reg [3:0] lock_cnt_r;
   always @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         lock_cnt_r <= 4'h0;
         LOCK_INDICATOR <= 1'b1;
      end else begin
         if ((up_r ^ dn_r) && !both) begin
            if (lock_cnt_r != LOCK_HOLD)
               lock_cnt_r <= lock_cnt_r + 4'h1;
         end else begin
            lock_cnt_r <= 4'h0;
         end
         LOCK_INDICATOR <= (lock_cnt_r != LOCK_HOLD);
      end
   end

   // Buffered divided-frequency outputs
   always @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         DIVIDED_VCO_FREQ <= 1'b0;
         DIVIDED_REF_FREQ <= 1'b0;
      end else begin
         DIVIDED_VCO_FREQ <= vco_evt_r;
         DIVIDED_REF_FREQ <= ref_evt_r;
      end
   end
endmodule

// file: dmpd_checker.sv
// Port checker for the PLL divider core
`timescale 1ns/100ps
module dmpd_checker (
   input wire SYS_CLK,
   input wire RESETN,
   input wire REF_OSC_INPUT,
   input wire [5:0] A_PRESET_VALUE,
   input wire REF_OSC_OUTPUT,
   input wire MODULUS_CONTROL,
   input wire PHASE_REF_N,
   input wire PHASE_VCO_N,
   input wire LOCK_INDICATOR,
   input wire DIVIDED_VCO_FREQ,
   input wire DIVIDED_REF_FREQ
);
   // One domain, so clock and reset stand once
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RESETN);
   ref_gap_a: assert property (DIVIDED_REF_FREQ |=> !DIVIDED_REF_FREQ [*8]) else $error("ref");
   vco_gap_a: assert property (DIVIDED_VCO_FREQ |=> !DIVIDED_VCO_FREQ [*8]) else $error("vco");
   osc_inv_a: assert property (REF_OSC_OUTPUT == !REF_OSC_INPUT) else $error("osc");
   mc_start_a: assert property (DIVIDED_VCO_FREQ && A_PRESET_VALUE != 6'h00 |-> !MODULUS_CONTROL)
      else $error("mc");
   both_low_a: assert property (!PHASE_REF_N && !PHASE_VCO_N |-> ##[1:2] (PHASE_REF_N && PHASE_VCO_N))
      else $error("pulse");
   ref_rel_a: assert property ($rose(PHASE_REF_N) |-> $rose(PHASE_VCO_N)) else $error("rel");
   vco_rel_a: assert property ($rose(PHASE_VCO_N) |-> $rose(PHASE_REF_N)) else $error("rel");
   lock_drop_a: assert property ($fell(LOCK_INDICATOR) |-> !$past(PHASE_REF_N) || !$past(PHASE_VCO_N))
      else $error("lock");
endmodule
bind dmpd_core dmpd_checker chk_i (
   .SYS_CLK(SYS_CLK),
   .RESETN(RESETN),
   .REF_OSC_INPUT(REF_OSC_INPUT),
   .A_PRESET_VALUE(A_PRESET_VALUE),
   .REF_OSC_OUTPUT(REF_OSC_OUTPUT),
   .MODULUS_CONTROL(MODULUS_CONTROL),
   .PHASE_REF_N(PHASE_REF_N),
   .PHASE_VCO_N(PHASE_VCO_N),
   .LOCK_INDICATOR(LOCK_INDICATOR),
   .DIVIDED_VCO_FREQ(DIVIDED_VCO_FREQ),
   .DIVIDED_REF_FREQ(DIVIDED_REF_FREQ)
);

// file: dmpd_presc.sv
// Dual-modulus prescaler model for the divider input pin
`timescale 1ns/100ps
module dmpd_presc #(parameter P = 2) (
   input wire clk,
   input wire run,
   input wire mc,
   output reg fout = 1'b0
);
   integer cnt = 0;
   integer len = 8;
   // Length chosen late in the period, once modulus control has settled
   always @(negedge clk) begin
      if (run) begin
         if (cnt == 6) len <= mc ? 4 * P : 4 * P + 4;
         cnt <= (cnt >= len - 1) ? 0 : cnt + 1;
      end
      fout <= run && cnt < 4;
   end
endmodule

// file: testbench.sv
// Self-checking bench for the PLL divider core
`timescale 1ns/100ps
module testbench;
   reg clk = 1'b0, rst_n = 1'b0, run = 1'b0, ref_run = 1'b0;
   reg [1:0] rc = 2'h0;
   reg [2:0] sel = 3'h0;
   reg [9:0] n_val = 10'h003;
   reg [5:0] a_val = 6'h00;
   wire divider_input, mc, ph_r, ph_v, lock, fv, fr;
   integer err_total = 0, n_compared = 0, cyc, lows, pr, pv, i, k;
   reg seen = 1'b0, hung = 1'b0; // Event found; a wait ran out
   always #25 clk = ~clk;
   // Reference pin at a quarter of the clock rate
   always @(negedge clk) if (ref_run) rc <= rc + 2'h1;
   dmpd_presc presc (.clk(clk), .run(run), .mc(mc), .fout(divider_input));
   dmpd_core dut (.SYS_CLK(clk), .RESETN(rst_n), .REF_OSC_INPUT(rc[1]), .DIVIDER_INPUT(divider_input),
      .REF_DIVIDE_SELECT(sel), .N_PRESET_VALUE(n_val), .A_PRESET_VALUE(a_val),
      .REF_OSC_OUTPUT(), .MODULUS_CONTROL(mc), .PHASE_REF_N(ph_r), .PHASE_VCO_N(ph_v),
      .LOCK_INDICATOR(lock), .DIVIDED_VCO_FREQ(fv), .DIVIDED_REF_FREQ(fr));
   task chk(input integer got, input integer exp);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task stop_test;
      begin
         $display("compared=%0d bad=%0d", n_compared, err_total);
         if (err_total == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   // Config only changes under reset, since the lines are static
   task restart(input [9:0] n, input [5:0] a, input [2:0] s, input v, input r);
      begin
         // Nonblocking, so the falling-edge models see a clean change
         @(negedge clk);
         rst_n <= 1'b0;
         {run, ref_run, n_val, a_val, sel} <= {v, r, n, a, s};
         repeat (8) @(negedge clk);
         rst_n <= 1'b1;
      end
   endtask
   // First pass syncs to an event; second counts the samples after it up to
   // and including the next one, so the window is one settled period
   task span(input w);
      begin
         i = 0;
         for (k = 0; k < 2; k = k + 1) begin
            cyc = 0;
            lows = 0;
            pr = 0;
            pv = 0;
            seen = 1'b0;
            while (!seen && !hung && i < 40000) begin
               @(negedge clk);
               i = i + 1;
               cyc = cyc + 1;
               lows = lows + !mc;
               pr = pr + !ph_r;
               pv = pv + !ph_v;
               seen = ((w ? fr : fv) === 1'b1);
            end
         end
         // A hang is counted once; later spans then return at once
         if (i >= 40000 && !hung) begin
            hung = 1'b1;
            $display("BAD t=%0t got=%h exp=%h", $time, i, 0);
            err_total = err_total + 1;
         end
      end
   endtask
   task t_counts(input [9:0] n, input [5:0] a);
      begin
         restart(n, a, 3'h0, 1'b1, 1'b0);
         span(1'b0);
         chk(cyc, 8 * n + 4 * a);
         chk(lows, 12 * a);
         chk(pr, 0);
         chk(pv == cyc, 1);
         chk(lock, 0);
         $display("counts n=%0d a=%0d done", n, a);
      end
   endtask
   task t_ref;
      integer s;
      begin
         for (s = 0; s < 8; s = s + 1) begin
            restart(10'h3ff, 6'h00, s[2:0], 1'b0, 1'b1);
            span(1'b1);
            chk(cyc, 4 * (s == 0 ? 8 : s == 6 ? 1160 : s == 7 ? 2048 : 32 << s));
            chk(pv, 0);
            chk(pr == cyc, 1);
         end
         $display("ratios done");
      end
   endtask
   task t_lock;
      begin
         restart(10'h004, 6'h00, 3'h0, 1'b1, 1'b1);
         span(1'b0);
         chk(cyc, 32);
         chk(pr > 1 && pv > 1, 1);
         $display("lock done");
      end
   endtask
   initial begin
      t_counts(10'h003, 6'h00);
      t_counts(10'h005, 6'h02);
      t_counts(10'h3ff, 6'h3f);
      t_ref;
      t_lock;
      stop_test;
   end
endmodule
